/* logic/input_pulse_filter.sv */
// Purpose: Glitch filter for sixteen discrete field inputs
// Assumes: Single 40 MHz clock; filter setting written by software logic on the same clock
// Notes:   Pins pass a three-stage synchroniser before filtering
// Timing walk with a zero step count
//   Edge 1: the pin level lands in synchroniser stage one
//   Edge 2: stage two takes it
//   Edge 3: stage three takes it
//   Edge 4: stages two and three agree, so the stable copy takes the level
//   Edge 5: the filtered output and the capture pulse show the change
//   The interrupt event pulse rises on that same edge as the filtered output
//   A pin that toggles every cycle never lets stages two and three agree,
//   so the stable copy holds its old level; this is the two-stage agreement rule
//
// Timing walk with a nonzero step count N
//   The base divider runs free while N is nonzero and pulses every base period
//   Each input counts base pulses while its stable level differs from its output
//   The count restarts whenever the stable level returns to the output level
//   The new level is taken on the base pulse that makes the count reach N
//   Because the divider is shared, the first counted pulse may come early;
//   the accepted delay therefore lies between N-1 and N base periods,
//   plus the five-edge pipeline of the synchroniser and output register
//   Trade-off: one shared divider instead of sixteen keeps the area small,
//   at the price of up to one base period of jitter on the delay
//
// Step count handling
//   The step count is written by logic on the same clock, one strobe a value
//   A new value takes effect at the next compare of every counter
//   Lowering the step below a running count accepts the level on the next pulse
//   Writing zero stops the divider and turns the filter transparent at once
//
// Edge outputs
//   Rising and falling edges of the filtered levels raise one-cycle pulses
//   Interrupt pulses are gated per input by the rise and fall enables
//   Capture pulses are gated per input by the capture enable, either direction
//   Pulses are not sticky: the consumer must look in the cycle they stand
//
// Limitations
//   No interrupt status is kept here; the consumer latches what it needs
//   No encoder position is stored here; the capture pulse only triggers it

`include "input_pulse_filter_consts.svh"

module input_pulse_filter (
  input  wire logic                                mclk,
  input  wire logic                                reset,
  input  wire input_pulse_filter_pkg::input_bank_type field_in,
  input  wire logic                                step_we,
  input  wire logic [7:0]                          step_wdata,
  input  wire logic [`INPUT_COUNT-1:0]             rise_en,
  input  wire logic [`INPUT_COUNT-1:0]             fall_en,
  input  wire logic [`INPUT_COUNT-1:0]             capture_en,
  output logic [7:0]                               step_count,
  output input_pulse_filter_pkg::input_bank_type   filtered_in,
  output logic [`INPUT_COUNT-1:0]                  irq_event,
  output logic [`INPUT_COUNT-1:0]                  capture_trigger
);

  localparam logic [10:0] BASE_LAST = 11'(`FILTER_BASE_CYC - 1);

  input_pulse_filter_pkg::filter_state_type s_r;
  input_pulse_filter_pkg::filter_state_type s_nxt;
  logic [7:0]                               step_r;
  logic [7:0]                               step_nxt;
  logic [`INPUT_COUNT-1:0]                  irq_r;
  logic [`INPUT_COUNT-1:0]                  irq_nxt;

  // True when synchroniser stages two and three agree
  function automatic logic [`INPUT_COUNT-1:0] agree(
    input logic [`INPUT_COUNT-1:0] a,
    input logic [`INPUT_COUNT-1:0] b
  );
    agree = ~(a ^ b);
  endfunction

  // Next state of the whole filter
  // Every path starts from the held state so nothing infers a latch
  always_comb begin
    logic [`INPUT_COUNT-1:0] raw;
    logic [`INPUT_COUNT-1:0] new_filt;
    logic [`INPUT_COUNT-1:0] agreed;
    raw      = '0;
    new_filt = '0;
    agreed   = '0;
    s_nxt    = s_r;
    step_nxt = step_r;
    if (step_we) begin
      step_nxt = step_wdata;
    end
    // Synchroniser: pin feeds stage 0, stage 0 feeds stage 1, stage 1 feeds stage 2
    s_nxt.sync[0] = field_in;
    s_nxt.sync[1] = s_r.sync[0];
    s_nxt.sync[2] = s_r.sync[1];
    // Only a level seen twice in a row is taken as stable
    agreed = agree(s_r.sync[1], s_r.sync[2]);
    for (int i = 0; i < `INPUT_COUNT; i++) begin
      if (agreed[i]) begin
        s_nxt.stable[i] = s_r.sync[2][i];
      end
    end
    raw = s_r.stable;
    // Base period tick; the divider idles while filtering is off to save toggling
    s_nxt.tick = 1'b0;
    case (s_r.tick_state)
      input_pulse_filter_pkg::ST_IDLE: begin
        s_nxt.base_cnt = '0;
        if (step_r != 8'h00) begin
          s_nxt.tick_state = input_pulse_filter_pkg::ST_RUN;
        end
      end
      input_pulse_filter_pkg::ST_RUN: begin
        if (step_r == 8'h00) begin
          s_nxt.tick_state = input_pulse_filter_pkg::ST_IDLE;
        end else if (s_r.base_cnt == BASE_LAST) begin
          s_nxt.base_cnt = '0;
          s_nxt.tick     = 1'b1;
        end else begin
          s_nxt.base_cnt = s_r.base_cnt + 11'h001;
        end
      end
      default: begin
        s_nxt.tick_state = input_pulse_filter_pkg::ST_IDLE;
        s_nxt.base_cnt   = '0;
      end
    endcase
    // Per-input counters; a level must outlast step_r ticks to pass
    for (int i = 0; i < `INPUT_COUNT; i++) begin
      new_filt[i] = s_r.filtered[i];
      if (step_r == 8'h00) begin
        new_filt[i]      = raw[i];
        s_nxt.step_cnt[i] = '0;
      end else if (raw[i] == s_r.filtered[i]) begin
        s_nxt.step_cnt[i] = '0;
      end else if (s_r.tick) begin
        if (s_r.step_cnt[i] + 8'h01 >= step_r) begin
          new_filt[i]       = raw[i];
          s_nxt.step_cnt[i] = '0;
        end else begin
          s_nxt.step_cnt[i] = s_r.step_cnt[i] + 8'h01;
        end
      end
    end
    s_nxt.filtered = new_filt;
    s_nxt.rise     = new_filt & ~s_r.filtered;
    s_nxt.fall     = ~new_filt & s_r.filtered;
    irq_nxt        = (s_nxt.rise & rise_en) | (s_nxt.fall & fall_en);
    s_nxt.capture  = (s_nxt.rise | s_nxt.fall) & capture_en;
  end

  // State register; async reset loads constants only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_r            <= '0;
      s_r.tick_state <= input_pulse_filter_pkg::ST_IDLE;
      step_r         <= `FILTER_STEP_RST;
      irq_r          <= '0;
    end else begin
      s_r    <= s_nxt;
      step_r <= step_nxt;
      irq_r  <= irq_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign step_count      = step_r;
  assign filtered_in     = s_r.filtered;
  assign irq_event       = irq_r;
  assign capture_trigger = s_r.capture;

endmodule // input_pulse_filter

/* logic/input_pulse_filter_consts.svh */
// Purpose: Constants for the discrete input glitch filter
// Assumes: 40 MHz system clock
// Notes:   Times are given in ns; cycle counts derive from them
`ifndef INPUT_PULSE_FILTER_CONSTS_SVH
`define INPUT_PULSE_FILTER_CONSTS_SVH

`define CLK_PERIOD_NS     25
`define FILTER_BASE_NS    31000
// Base step is a longest-time figure, so it rounds down (31000/25 = 1240 exactly)
`define FILTER_BASE_CYC   (`FILTER_BASE_NS / `CLK_PERIOD_NS)
`define FILTER_STEP_RST   8'h00
`define INPUT_COUNT       16
`define GROUP_WIDTH       8

`endif

/* logic/input_pulse_filter_pkg.sv */
// Purpose: Types for the discrete input glitch filter
// Assumes: Constants header supplies widths
// Notes:   Inputs travel as two groups of eight
`include "input_pulse_filter_consts.svh"

package input_pulse_filter_pkg;

  // Sixteen field inputs split into two groups
  typedef struct packed {
    logic [`GROUP_WIDTH-1:0] input_group_high;
    logic [`GROUP_WIDTH-1:0] input_group_low;
  } input_bank_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } tick_state_type;

  typedef struct packed {
    logic [2:0][`INPUT_COUNT-1:0] sync;
    logic [`INPUT_COUNT-1:0]      stable;
    logic [10:0]                  base_cnt;
    logic                         tick;
    tick_state_type               tick_state;
    logic [`INPUT_COUNT-1:0][7:0] step_cnt;
    logic [`INPUT_COUNT-1:0]      filtered;
    logic [`INPUT_COUNT-1:0]      rise;
    logic [`INPUT_COUNT-1:0]      fall;
    logic [`INPUT_COUNT-1:0]      capture;
  } filter_state_type;

endpackage

/* testbench/field_switch_model.sv */
// Purpose: Field contacts on the sixteen discrete inputs
// Assumes: Bench commands the contact levels shortly after each clock edge
// Notes:   Glitches are commanded as short level pulses, no built-in bounce
module field_switch_model (
  input  wire logic [15:0]                         lvl,
  output input_pulse_filter_pkg::input_bank_type   pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both groups of eight are wired straight through
  assign pins = lvl;
endmodule // field_switch_model

/* testbench/input_pulse_filter_chk.sv */
// Purpose: Port assertions for the input glitch filter
// Assumes: Enables held steady; raw-to-filtered latency of five edges
// Notes:   Hold-off check only covers steps of two or more
module input_pulse_filter_chk (
  input wire logic                                  mclk,
  input wire logic                                  reset,
  input wire input_pulse_filter_pkg::input_bank_type field_in,
  input wire logic                                  step_we,
  input wire logic [7:0]                            step_wdata,
  input wire logic [15:0]                           rise_en,
  input wire logic [15:0]                           fall_en,
  input wire logic [15:0]                           capture_en,
  input wire logic [7:0]                            step_count,
  input wire input_pulse_filter_pkg::input_bank_type filtered_in,
  input wire logic [15:0]                           irq_event,
  input wire logic [15:0]                           capture_trigger
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Raw level that lines up with the filtered output
  sequence agreed_s; step_count > 8'h01 && filtered_in == $past(field_in, 5); endsequence
  sequence diverge_s; filtered_in != $past(field_in, 5); endsequence
  AST_RESET_VAL: assert property ($fell(reset) |-> step_count == 8'h00 && filtered_in == 16'h0000)
    else $error("reset values wrong");
  AST_STEP_WR: assert property (step_we |=> step_count == $past(step_wdata)) else $error("step lost");
  AST_STEP_HOLD: assert property (!step_we |=> $stable(step_count)) else $error("step drifted");
  AST_PASS: assert property ((step_count == 8'h00) [*6] |->
    ((filtered_in ^ $past(field_in, 5)) & ~($past(field_in, 5) ^ $past(field_in, 4))) == 16'h0000)
    else $error("zero filter not transparent");
  AST_NEW_LEVEL: assert property (((filtered_in ^ $past(filtered_in)) & (filtered_in ^ $past(field_in, 5))) == 16'h0000)
    else $error("filtered took an unseen level");
  // A fresh raw change cannot mature within a few cycles when the step is two or more
  AST_HOLD_OFF: assert property (agreed_s ##1 diverge_s |-> (step_count < 8'h02 || $stable(filtered_in)) [*8])
    else $error("short pulse passed");
  AST_CAPTURE: assert property (capture_trigger == ((filtered_in ^ $past(filtered_in)) & capture_en))
    else $error("capture pulse wrong");
  AST_IRQ: assert property (irq_event == ((filtered_in & ~$past(filtered_in) & rise_en)
    | (~filtered_in & $past(filtered_in) & fall_en))) else $error("edge event wrong");
endmodule // input_pulse_filter_chk
bind input_pulse_filter input_pulse_filter_chk u_chk (.*);

/* testbench/tb_top.sv */
// Purpose: Self-checking bench for the input glitch filter
// Assumes: 40 MHz clock; pins driven through the switch model
// Notes:   Step of two keeps the long counts short
`include "input_pulse_filter_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                                   mclk = 1'b0;
  logic                                   reset = 1'b1;
  logic                                   step_we = 1'b0;
  logic [7:0]                             step_wdata = 8'h00;
  logic [15:0]                            lvl = 16'h0000;
  logic [7:0]                             step_count;
  logic [15:0]                            irq_event;
  logic [15:0]                            capture_trigger;
  input_pulse_filter_pkg::input_bank_type field_in;
  input_pulse_filter_pkg::input_bank_type filtered_in;
  int                                     bad_count = 0;
  int                                     num_checks = 0;
  int                                     seed = 99;
  int                                     d;
  logic [15:0]                            old_f;
  field_switch_model u_field_switch_model (.lvl(lvl), .pins(field_in));
  input_pulse_filter u_input_pulse_filter (.mclk(mclk), .reset(reset), .field_in(field_in), .step_we(step_we),
    .step_wdata(step_wdata), .rise_en(16'hA5A5), .fall_en(16'h3C3C), .capture_en(16'hFFFF),
    .step_count(step_count), .filtered_in(filtered_in), .irq_event(irq_event), .capture_trigger(capture_trigger));
  // Clock and hang guard
  initial forever #12.5 mclk = ~mclk;
  initial begin
    #500us;
    bad_count++;
    report_and_stop();
  end
  // Accepted delay lies between one step short and the full time, plus pipeline
  function automatic logic in_win(input int dly, input int n);
    return dly >= (n - 1) * `FILTER_BASE_CYC && dly <= n * `FILTER_BASE_CYC + 5;
  endfunction
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] v);
    @(posedge mclk) #1 step_we = 1'b1;
    step_wdata = v;
    @(posedge mclk) #1 step_we = 1'b0;
    chk(step_count === v, "step readback");
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: pass-through, boundary step, glitch, long level
  initial begin
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    chk(step_count === 8'h00 && filtered_in === 16'h0000, "reset values");
    repeat (200) @(posedge mclk) #1 lvl = 16'($random(seed));
    repeat (6) @(posedge mclk);
    #1 chk(filtered_in === lvl, "pass-through");
    wr(8'hFF);
    wr(8'h02);
    lvl = lvl ^ 16'h0101;
    repeat (1000) @(posedge mclk);
    #1 chk(filtered_in === (lvl ^ 16'h0101), "glitch passed early");
    lvl = lvl ^ 16'h0101;
    repeat (3000) @(posedge mclk);
    #1 chk(filtered_in === lvl, "glitch survived");
    old_f = filtered_in;
    lvl = lvl ^ (16'($random(seed)) | 16'h8000);
    d = 0;
    while (filtered_in !== lvl && d < 4000) begin
      @(posedge mclk);
      #1 d++;
    end
    chk(in_win(d, 2), "filter delay");
    chk(capture_trigger === (old_f ^ lvl), "capture pulse");
    chk(irq_event === (((lvl & ~old_f) & 16'hA5A5) | ((~lvl & old_f) & 16'h3C3C)), "edge event");
    wr(8'h00);
    report_and_stop();
  end
endmodule // tb_top
